// File: core/sdsic_device.sv
// Device end: serial capture, clock detection, zero flag and soft mute.
// Assumes the link's clocks come from the source through sdsic_if.
`timescale 1ns/1ns
`include "sdsic_params.svh"
module sdsic_device #(
  parameter int ZERO_FRAMES = `SDSIC_ZERO_FRAMES,
  parameter int MUTE_FRAMES = `SDSIC_MUTE_FRAMES
) (
  sdsic_if.device               link,
  input  wire logic             rst,
  output logic signed [23:0]    leftOut,
  output logic signed [23:0]    rightOut,
  output logic                  outValid,
  output logic                  rateTick,
  output sdsic_pkg::sdsic_ratio_t  ratioSeen,
  output logic                  doubleRateOn,
  output sdsic_pkg::sdsic_deemph_t deemphSel,
  output sdsic_pkg::sdsic_analog_t analogMode,
  output logic [10:0]           gainLevel
);
  localparam logic [10:0] GAIN_FULL = 11'h400;
  localparam logic [10:0] GAIN_STEP = 11'(1024 / MUTE_FRAMES);
  localparam logic [13:0] ZERO_LAST = 14'(ZERO_FRAMES - 1);

  function automatic logic [23:0] extract(input logic [31:0] s,
                                          input logic [5:0]  n,
                                          input sdsic_pkg::sdsic_format_t f);
    logic [31:0] t;
    t = s;
    if (n > 6'd24)
      t = s >> (n - 6'd24);
    unique case (f)
      sdsic_pkg::FMT_LSB16: extract = {s[15:0], 8'h00};
      sdsic_pkg::FMT_LSB20: extract = {s[19:0], 4'h0};
      sdsic_pkg::FMT_LSB24: extract = s[23:0];
      default:              extract = t[23:0];
    endcase
  endfunction

  function automatic logic signed [23:0] scale(input logic signed [23:0] v,
                                               input logic [10:0] g);
    logic signed [35:0] p;
    p = v * $signed({1'b0, g});
    return p[33:10];
  endfunction

  function automatic sdsic_pkg::sdsic_ratio_t ratioOf(input logic [10:0] n,
                                                     input logic dbl);
    logic [10:0] u;
    u = dbl ? (n << 1) : n;
    unique case (u)
      11'h100: ratioOf = sdsic_pkg::RATIO_X1;
      11'h180: ratioOf = sdsic_pkg::RATIO_X1P5;
      11'h200: ratioOf = sdsic_pkg::RATIO_X2;
      11'h300: ratioOf = sdsic_pkg::RATIO_X3;
      default: ratioOf = sdsic_pkg::RATIO_NONE;
    endcase
  endfunction

  logic pdReset;
  assign pdReset = rst | ~link.powerDownN;

  // Bit clock domain.
  logic [3:0]  fmtSync;
  sdsic_pkg::sdsic_format_t fmtB;
  logic        isI2s;
  logic        frameD1_r, frameD2_r, pairTgl_r;
  logic [31:0] shift_r;
  logic [5:0]  bitCnt_r;
  logic [23:0] leftHold_r, rightHold_r, leftPair_r, rightPair_r;
  logic        boundary, prevLevel;
  logic [23:0] word;

  sdsic_sync #(.WIDTH(4)) uFmtSync (
    .clk  (link.bitClock),
    .rst  (pdReset),
    .din  ({link.pinControl, link.formatCode}),
    .dout (fmtSync)
  );
  assign fmtB = sdsic_pkg::effFormat(fmtSync[3], fmtSync[2:0]);
  assign isI2s = (fmtB == sdsic_pkg::FMT_I2S24);
  // I2S words start one bit late, so its boundary uses the delayed frame.
  assign boundary  = isI2s ? (frameD1_r != frameD2_r)
                           : (link.frameClock != frameD1_r);
  assign prevLevel = isI2s ? frameD2_r : frameD1_r;
  assign word      = extract(shift_r, bitCnt_r, fmtB);

  always_ff @(posedge link.bitClock or posedge pdReset) begin
    if (pdReset) begin
      frameD1_r <= 1'b0;
      frameD2_r <= 1'b0;
      shift_r   <= 32'h0;
      bitCnt_r  <= 6'h0;
    end else begin
      frameD1_r <= link.frameClock;
      frameD2_r <= frameD1_r;
      shift_r   <= {shift_r[30:0], link.serialSample};
      if (boundary)
        bitCnt_r <= 6'h1;
      else if (bitCnt_r < 6'(`SDSIC_HALF_BITS))
        bitCnt_r <= bitCnt_r + 6'h1;
    end
  end

  always_ff @(posedge link.bitClock or posedge pdReset) begin
    if (pdReset) begin
      leftHold_r  <= 24'h0;
      rightHold_r <= 24'h0;
      leftPair_r  <= 24'h0;
      rightPair_r <= 24'h0;
      pairTgl_r   <= 1'b0;
    end else if (boundary) begin
      if (prevLevel == ~isI2s) begin
        leftHold_r <= word;
      end else begin
        leftPair_r  <= leftHold_r;
        rightPair_r <= word;
        pairTgl_r   <= ~pairTgl_r;
      end
    end
  end

  // Master clock domain.
  logic [8:0] ctlSync;
  logic       pdnOk, pinS, frameS, rstReqS, rstnS, muteS, dfsS, tglS;
  logic [1:0] demS;
  logic       frameD_r, tglD_r, intRstN_r, zeroFlag_r;
  logic       frameRise, newPair, digitalOn;
  logic [10:0] mclkCnt_r, acc_r, stepVal, ratioCnt_r;
  logic [1:0] lagCnt_r;
  logic [2:0] relCnt_r;
  logic [13:0] zeroCnt_r;
  logic signed [23:0] leftS_r, rightS_r;
  sdsic_pkg::sdsic_state_t state_r;

  // The reset bit passes inverted so that a cleared flop reads as idle.
  sdsic_sync #(.WIDTH(9)) uCtlSync (
    .clk  (link.masterClock),
    .rst  (pdReset),
    .din  ({1'b1, link.pinControl, link.frameClock, ~link.timingResetN,
            link.softMute, link.doubleRate, link.deemphCode, pairTgl_r}),
    .dout (ctlSync)
  );
  assign {pdnOk, pinS, frameS, rstReqS, muteS, dfsS, demS, tglS} = ctlSync;
  assign rstnS     = ~rstReqS;
  assign frameRise = frameS & ~frameD_r;
  assign newPair   = tglS ^ tglD_r;
  assign digitalOn = (state_r == sdsic_pkg::ST_RUN) & intRstN_r;
  assign stepVal   = dfsS ? 11'(`SDSIC_STEP_DOUBLE)
                          : 11'(`SDSIC_STEP_NORMAL);

  always_ff @(posedge link.masterClock or posedge pdReset) begin
    if (pdReset) begin
      frameD_r   <= 1'b0;
      tglD_r     <= 1'b0;
      mclkCnt_r  <= 11'h0;
      ratioCnt_r <= 11'h0;
      ratioSeen  <= sdsic_pkg::RATIO_NONE;
      acc_r      <= 11'h0;
      rateTick   <= 1'b0;
    end else begin
      frameD_r <= frameS;
      tglD_r   <= tglS;
      if (frameRise) begin
        mclkCnt_r  <= 11'h1;
        ratioCnt_r <= mclkCnt_r;
        ratioSeen  <= ratioOf(mclkCnt_r, dfsS);
      end else if (mclkCnt_r != 11'h7FF) begin
        mclkCnt_r <= mclkCnt_r + 11'h1;
      end
      // Fractional divider gives 256 or 128 ticks per frame.
      if (ratioSeen == sdsic_pkg::RATIO_NONE) begin
        acc_r    <= 11'h0;
        rateTick <= 1'b0;
      end else if (acc_r + stepVal >= ratioCnt_r) begin
        acc_r    <= acc_r + stepVal - ratioCnt_r;
        rateTick <= 1'b1;
      end else begin
        acc_r    <= acc_r + stepVal;
        rateTick <= 1'b0;
      end
    end
  end

  always_ff @(posedge link.masterClock or posedge pdReset) begin
    if (pdReset)
      state_r <= sdsic_pkg::ST_POWERDOWN;
    else
      unique case (state_r)
        sdsic_pkg::ST_POWERDOWN:
          if (pdnOk)
            state_r <= sdsic_pkg::ST_WAITCLK;
        sdsic_pkg::ST_WAITCLK:
          if (frameRise && ratioSeen != sdsic_pkg::RATIO_NONE)
            state_r <= sdsic_pkg::ST_RUN;
        sdsic_pkg::ST_RUN:
          state_r <= sdsic_pkg::ST_RUN;
        default:
          state_r <= sdsic_pkg::ST_POWERDOWN;
      endcase
  end

  always_ff @(posedge link.masterClock or posedge pdReset) begin
    if (pdReset) begin
      intRstN_r <= 1'b1;
      lagCnt_r  <= 2'h0;
    end else if (rstnS == intRstN_r) begin
      lagCnt_r <= 2'h0;
    end else if (frameRise) begin
      if (lagCnt_r + 2'h1 == (rstnS ? 2'(`SDSIC_RST_RELEASE)
                                    : 2'(`SDSIC_RST_ASSERT))) begin
        intRstN_r <= rstnS;
        lagCnt_r  <= 2'h0;
      end else begin
        lagCnt_r <= lagCnt_r + 2'h1;
      end
    end
  end

  always_ff @(posedge link.masterClock or posedge pdReset) begin
    if (pdReset) begin
      zeroFlag_r <= 1'b0;
      zeroCnt_r  <= 14'h0;
      relCnt_r   <= 3'h0;
    end else if (!rstnS) begin
      zeroFlag_r <= 1'b1;
      zeroCnt_r  <= 14'h0;
      relCnt_r   <= 3'(`SDSIC_ZFLAG_RELEASE);
    end else if (relCnt_r != 3'h0) begin
      if (frameRise)
        relCnt_r <= relCnt_r - 3'h1;
      if (frameRise && relCnt_r == 3'h1)
        zeroFlag_r <= 1'b0;
    end else if (newPair && digitalOn) begin
      if (leftPair_r != 24'h0 || rightPair_r != 24'h0) begin
        zeroFlag_r <= 1'b0;
        zeroCnt_r  <= 14'h0;
      end else if (zeroCnt_r == ZERO_LAST) begin
        zeroFlag_r <= 1'b1;
      end else begin
        zeroCnt_r <= zeroCnt_r + 14'h1;
      end
    end
  end
  assign link.zeroInputFlag = zeroFlag_r;

  always_ff @(posedge link.masterClock or posedge pdReset) begin
    if (pdReset) begin
      gainLevel <= GAIN_FULL;
    end else if (frameRise && digitalOn) begin
      if (muteS && gainLevel != 11'h0)
        gainLevel <= gainLevel - GAIN_STEP;
      else if (!muteS && gainLevel != GAIN_FULL)
        gainLevel <= gainLevel + GAIN_STEP;
    end
  end

  always_ff @(posedge link.masterClock or posedge pdReset) begin
    if (pdReset) begin
      leftS_r  <= 24'sh0;
      rightS_r <= 24'sh0;
      leftOut  <= 24'sh0;
      rightOut <= 24'sh0;
      outValid <= 1'b0;
    end else begin
      outValid <= newPair & digitalOn;
      if (!digitalOn) begin
        leftOut  <= 24'sh0;
        rightOut <= 24'sh0;
      end else if (newPair) begin
        leftS_r  <= $signed(leftPair_r);
        rightS_r <= $signed(rightPair_r);
        leftOut  <= scale($signed(leftPair_r), gainLevel);
        rightOut <= scale($signed(rightPair_r), gainLevel);
      end
    end
  end

  always_ff @(posedge link.masterClock or posedge pdReset) begin
    if (pdReset) begin
      analogMode   <= sdsic_pkg::OUT_HIZ;
      doubleRateOn <= 1'b0;
      deemphSel    <= sdsic_pkg::DEM_OFF;
    end else begin
      if (state_r != sdsic_pkg::ST_RUN)
        analogMode <= sdsic_pkg::OUT_HIZ;
      else if (!intRstN_r)
        analogMode <= sdsic_pkg::OUT_COMMON;
      else
        analogMode <= sdsic_pkg::OUT_ACTIVE;
      doubleRateOn <= dfsS;
      deemphSel    <= pinS ? sdsic_pkg::DEM_OFF
                           : sdsic_pkg::sdsic_deemph_t'(demS);
    end
  end
endmodule

// File: core/sdsic_host.sv
// Source end: divides its clock into the link clocks and frames samples.
// Assumes clk at 100 MHz; bit clock is 64 frames, master clock 256.
`timescale 1ns/1ns
`include "sdsic_params.svh"
module sdsic_host (
  sdsic_if.host      link,
  input  wire logic  clk,
  input  wire logic  rst,
  input  wire logic [23:0] leftIn,
  input  wire logic [23:0] rightIn,
  input  wire logic  clocksOn,
  input  wire logic  powerUpReq,
  input  wire logic  pinCtlReq,
  input  wire logic [2:0] formatReq,
  input  wire logic [1:0] deemphReq,
  input  wire logic  doubleReq,
  input  wire logic  muteReq,
  input  wire logic  timingResetReq,
  output logic       sampleTaken,
  output logic       zeroSeen,
  output logic       externalMute
);
  logic [2:0]  phase_r;
  logic [5:0]  bitPos_r, nextPos;
  logic        mclk_r, bck_r, frame_r, data_r, pdn_r;
  logic [23:0] leftW_r, rightW_r;
  logic [31:0] slot;
  sdsic_pkg::sdsic_format_t fmt;

  function automatic logic [31:0] slotOf(input logic [23:0] w,
                                         input sdsic_pkg::sdsic_format_t f);
    unique case (f)
      sdsic_pkg::FMT_LSB16: slotOf = {16'h0000, w[23:8]};
      sdsic_pkg::FMT_LSB20: slotOf = {12'h000, w[23:4]};
      sdsic_pkg::FMT_LSB24: slotOf = {8'h00, w};
      sdsic_pkg::FMT_I2S24: slotOf = {1'b0, w, 7'h00};
      default:              slotOf = {w, 8'h00};
    endcase
  endfunction

  assign fmt     = sdsic_pkg::effFormat(pinCtlReq, formatReq);
  assign nextPos = bitPos_r + 6'h1;
  assign slot    = slotOf(nextPos[5] ? rightW_r : leftW_r, fmt);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_r  <= 3'h0;
      mclk_r   <= 1'b0;
      bck_r    <= 1'b0;
      bitPos_r <= 6'h3F;
      frame_r  <= 1'b0;
      data_r   <= 1'b0;
    end else if (clocksOn) begin
      phase_r <= phase_r + 3'h1;
      mclk_r  <= ~mclk_r;
      if (phase_r == 3'h3)
        bck_r <= 1'b1;
      if (phase_r == 3'h7) begin
        bck_r    <= 1'b0;
        bitPos_r <= nextPos;
        frame_r  <= (fmt == sdsic_pkg::FMT_I2S24) ? nextPos[5]
                                                  : ~nextPos[5];
        data_r   <= slot[5'h1F - nextPos[4:0]];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      leftW_r     <= 24'h0;
      rightW_r    <= 24'h0;
      sampleTaken <= 1'b0;
    end else begin
      sampleTaken <= clocksOn && phase_r == 3'h3 && bitPos_r == 6'h3F;
      if (clocksOn && phase_r == 3'h3 && bitPos_r == 6'h3F) begin
        leftW_r  <= leftIn;
        rightW_r <= rightIn;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pdn_r        <= 1'b0;
      externalMute <= 1'b1;
    end else begin
      pdn_r        <= powerUpReq & clocksOn;
      externalMute <= ~(powerUpReq & clocksOn & pdn_r);
    end
  end

  logic zeroSync;
  sdsic_sync #(.WIDTH(1)) uZeroSync (
    .clk  (clk),
    .rst  (rst),
    .din  (link.zeroInputFlag),
    .dout (zeroSync)
  );
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      zeroSeen <= 1'b0;
    else
      zeroSeen <= zeroSync;
  end

  assign link.masterClock  = mclk_r;
  assign link.bitClock     = bck_r;
  assign link.frameClock   = frame_r;
  assign link.serialSample = data_r;
  assign link.powerDownN   = pdn_r;
  assign link.pinControl   = pinCtlReq;
  assign link.formatCode   = formatReq;
  assign link.deemphCode   = deemphReq;
  assign link.doubleRate   = doubleReq;
  assign link.softMute     = muteReq;
  assign link.timingResetN = ~timingResetReq;
endmodule

// File: core/sdsic_if.sv
// Link between the audio source and the serial input control.
// Assumes the source drives every clock and control signal.
`timescale 1ns/1ns
interface sdsic_if;
  logic       masterClock;
  logic       bitClock;
  logic       frameClock;
  logic       serialSample;
  logic       powerDownN;
  logic       pinControl;
  logic [2:0] formatCode;
  logic [1:0] deemphCode;
  logic       doubleRate;
  logic       softMute;
  logic       timingResetN;
  logic       zeroInputFlag;
  modport device (
    input  masterClock,
    input  bitClock,
    input  frameClock,
    input  serialSample,
    input  powerDownN,
    input  pinControl,
    input  formatCode,
    input  deemphCode,
    input  doubleRate,
    input  softMute,
    input  timingResetN,
    output zeroInputFlag
  );
  modport host (
    output masterClock,
    output bitClock,
    output frameClock,
    output serialSample,
    output powerDownN,
    output pinControl,
    output formatCode,
    output deemphCode,
    output doubleRate,
    output softMute,
    output timingResetN,
    input  zeroInputFlag
  );
endinterface

// File: core/sdsic_params.svh
// Constants shared by the serial-input control design.
// Assumes inclusion by bare name from the files under core/.
`ifndef SDSIC_PARAMS_SVH
`define SDSIC_PARAMS_SVH
`define SDSIC_ZERO_FRAMES   8192
`define SDSIC_MUTE_FRAMES   1024
`define SDSIC_RST_ASSERT    3
`define SDSIC_RST_RELEASE   2
`define SDSIC_ZFLAG_RELEASE 4
`define SDSIC_STEP_NORMAL   256
`define SDSIC_STEP_DOUBLE   128
`define SDSIC_FMT_DEFAULT   3'h3
`define SDSIC_DEM_DEFAULT   2'h1
`define SDSIC_HALF_BITS     32
`endif

// File: core/sdsic_pkg.sv
// Types and the framing decode shared by both ends.
// Assumes nothing beyond the constants header.
package sdsic_pkg;
  typedef enum logic [2:0] {
    FMT_LSB16 = 3'h0,
    FMT_LSB20 = 3'h1,
    FMT_MSB24 = 3'h2,
    FMT_I2S24 = 3'h3,
    FMT_LSB24 = 3'h4
  } sdsic_format_t;
  typedef enum logic [1:0] {
    DEM_44K1 = 2'h0,
    DEM_OFF  = 2'h1,
    DEM_48K  = 2'h2,
    DEM_32K  = 2'h3
  } sdsic_deemph_t;
  typedef enum logic [2:0] {
    RATIO_NONE = 3'h0,
    RATIO_X1   = 3'h1,
    RATIO_X1P5 = 3'h2,
    RATIO_X2   = 3'h3,
    RATIO_X3   = 3'h4
  } sdsic_ratio_t;
  typedef enum logic [1:0] {
    OUT_HIZ    = 2'h0,
    OUT_COMMON = 2'h1,
    OUT_ACTIVE = 2'h2
  } sdsic_analog_t;
  typedef enum logic [1:0] {
    ST_POWERDOWN = 2'h0,
    ST_WAITCLK   = 2'h1,
    ST_RUN       = 2'h2
  } sdsic_state_t;

  function automatic sdsic_format_t effFormat(input logic       pinCtl,
                                               input logic [2:0] code);
    sdsic_format_t f;
    f = FMT_I2S24;
    if (pinCtl)
      f = code[0] ? FMT_I2S24 : FMT_MSB24;
    else if (code <= 3'h4)
      f = sdsic_format_t'(code);
    return f;
  endfunction
endpackage

// File: core/sdsic_sync.sv
// Two-flop synchroniser for a bundle of levels.
// Assumes each bit is a slow level or a toggle.
`timescale 1ns/1ns
module sdsic_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      dout   <= '0;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule

// File: verif/sdsic_asserts.sv
// Checker on the link between the source end and the device end.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/1ns
module sdsic_asserts #(
  parameter int ZERO_FRAMES = 8192
) (
  input wire logic masterClock,
  input wire logic bitClock,
  input wire logic frameClock,
  input wire logic serialSample,
  input wire logic powerDownN,
  input wire logic softMute,
  input wire logic timingResetN,
  input wire logic zeroInputFlag
);
  logic [19:0] zeroRun;
  logic [5:0]  halfCnt;
  logic        started;
  logic        lastFrame;
  logic        primed;

  // Counts bit clocks since the last one bit on the data line or the last clock in timing reset.
  always_ff @(posedge bitClock or negedge powerDownN) begin
    if (!powerDownN)
      zeroRun <= 20'h00000;
    else if (serialSample || !timingResetN)
      zeroRun <= 20'h00000;
    else if (zeroRun != 20'hFFFFF)
      zeroRun <= zeroRun + 20'h00001;
  end

  // Counts bit clocks in each half of the frame.
  always_ff @(posedge bitClock or negedge powerDownN) begin
    if (!powerDownN) begin
      halfCnt   <= 6'h00;
      started   <= 1'h0;
      lastFrame <= 1'h0;
      primed    <= 1'h0;
    end else begin
      lastFrame <= frameClock;
      primed    <= 1'h1;
      halfCnt   <= (frameClock != lastFrame) ? 6'h01 : halfCnt + 6'h01;
      if (frameClock != lastFrame && primed)
        started <= 1'h1;
    end
  end

  property p_frame_edge;
    @(posedge masterClock) disable iff (!powerDownN)
      $changed(frameClock) |-> !bitClock;
  endproperty
  property p_data_edge;
    @(posedge masterClock) disable iff (!powerDownN)
      $changed(serialSample) |-> !bitClock;
  endproperty
  property p_half_len;
    @(posedge bitClock) disable iff (!powerDownN)
      (frameClock != lastFrame) && started |-> halfCnt == 6'h20;
  endproperty
  property p_bck_run;
    @(posedge masterClock) disable iff (!powerDownN)
      $stable(bitClock) |=> $changed(bitClock);
  endproperty
  property p_zero_early;
    @(posedge masterClock) disable iff (!powerDownN)
      $rose(zeroInputFlag) && timingResetN
        |-> int'(zeroRun) >= (ZERO_FRAMES - 1) * 64;
  endproperty
  property p_zero_late;
    @(posedge bitClock) disable iff (!powerDownN)
      int'(zeroRun) == (ZERO_FRAMES + 6) * 64 |-> zeroInputFlag;
  endproperty
  property p_nonzero_drop;
    @(posedge bitClock) disable iff (!powerDownN)
      serialSample && zeroInputFlag && timingResetN
        |-> ##[1:300] !zeroInputFlag;
  endproperty
  property p_rst_hold;
    @(posedge masterClock) disable iff (!powerDownN)
      (!timingResetN) [*6] |-> zeroInputFlag;
  endproperty
  property p_rst_release;
    @(posedge frameClock) disable iff (!powerDownN)
      $rose(timingResetN) |-> zeroInputFlag [*3] ##[1:3] !zeroInputFlag;
  endproperty
  property p_pd_flag;
    @(posedge masterClock) !powerDownN |-> !zeroInputFlag;
  endproperty

  a_frame_edge: assert property (p_frame_edge)
    else $error("frame clock moved while bit clock high");
  a_data_edge: assert property (p_data_edge)
    else $error("data moved while bit clock high");
  a_half_len: assert property (p_half_len)
    else $error("frame half not 32 bit clocks");
  a_bck_run: assert property (p_bck_run)
    else $error("bit clock stopped while powered");
  a_zero_early: assert property (p_zero_early)
    else $error("zero flag rose too early");
  a_zero_late: assert property (p_zero_late)
    else $error("zero flag missing after long zero run");
  a_nonzero_drop: assert property (p_nonzero_drop)
    else $error("zero flag kept after nonzero data");
  a_rst_hold: assert property (p_rst_hold)
    else $error("zero flag low in timing reset");
  a_rst_release: assert property (p_rst_release)
    else $error("zero flag release out of window");
  a_pd_flag: assert property (p_pd_flag)
    else $error("zero flag high in power down");

  c_flag: cover property (@(posedge masterClock) $rose(zeroInputFlag));
  c_trst: cover property (@(posedge masterClock) $fell(timingResetN));
  c_mute: cover property (@(posedge masterClock) $rose(softMute));
  c_pd: cover property (@(posedge masterClock) $fell(powerDownN));
endmodule

// File: verif/tb_top.sv
// Bench joining the source end and the device end over one link.
// Assumes the core files compile first; zero and mute counts are short.
`timescale 1ns/1ns
module tb_top;
  localparam int ZERO  = 16;
  localparam int MUTE  = 8;
  localparam int FRAME = 512;
  localparam int LIMIT = 95000;
  typedef struct packed {
    logic       pin;
    logic [2:0] fmt;
    logic [1:0] dem;
    logic       dbl;
    logic       chk;
    logic [1:0] expDem;
  } sdsic_row_t;
  sdsic_row_t rows [7] = '{
    '{1'h0, 3'h0, 2'h0, 1'h0, 1'h0, 2'h0},
    '{1'h0, 3'h1, 2'h2, 1'h1, 1'h0, 2'h2},
    '{1'h0, 3'h2, 2'h3, 1'h0, 1'h1, 2'h3},
    '{1'h0, 3'h3, 2'h1, 1'h0, 1'h1, 2'h1},
    '{1'h0, 3'h4, 2'h0, 1'h1, 1'h1, 2'h0},
    '{1'h1, 3'h0, 2'h0, 1'h0, 1'h1, 2'h1},
    '{1'h1, 3'h1, 2'h2, 1'h0, 1'h1, 2'h1}};
  logic                     clk, rst, clocksOn, powerUpReq, pinCtlReq;
  logic                     doubleReq, muteReq, timingResetReq;
  logic [23:0]              leftIn, rightIn;
  logic [2:0]               formatReq;
  logic [1:0]               deemphReq;
  logic                     zeroSeen, externalMute, doubleRateOn;
  logic signed [23:0]       leftOut, rightOut;
  logic [10:0]              gainLevel;
  sdsic_pkg::sdsic_ratio_t  ratioSeen;
  sdsic_pkg::sdsic_deemph_t deemphSel;
  sdsic_pkg::sdsic_analog_t analogMode;
  int                       cycles = 0, nFail = 0, checked = 0;

  sdsic_if link ();
  sdsic_host i_sdsic_host (.link(link), .clk(clk), .rst(rst),
    .leftIn(leftIn), .rightIn(rightIn), .clocksOn(clocksOn),
    .powerUpReq(powerUpReq), .pinCtlReq(pinCtlReq),
    .formatReq(formatReq), .deemphReq(deemphReq), .doubleReq(doubleReq),
    .muteReq(muteReq), .timingResetReq(timingResetReq),
    .sampleTaken(), .zeroSeen(zeroSeen), .externalMute(externalMute));
  sdsic_device #(.ZERO_FRAMES(ZERO), .MUTE_FRAMES(MUTE)) i_sdsic_device (
    .link(link), .rst(rst), .leftOut(leftOut), .rightOut(rightOut),
    .outValid(), .rateTick(), .ratioSeen(ratioSeen),
    .doubleRateOn(doubleRateOn), .deemphSel(deemphSel),
    .analogMode(analogMode), .gainLevel(gainLevel));
  sdsic_asserts #(.ZERO_FRAMES(ZERO)) chk (
    .masterClock(link.masterClock), .bitClock(link.bitClock),
    .frameClock(link.frameClock), .serialSample(link.serialSample),
    .powerDownN(link.powerDownN), .softMute(link.softMute),
    .timingResetN(link.timingResetN), .zeroInputFlag(link.zeroInputFlag));

  always #5 clk = ~clk;

  // Cuts a hang short.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      nFail = nFail + 1;
      stopTest();
    end
  end

  task automatic stopTest();
    $display("checks %0d mismatches %0d", checked, nFail);
    if (nFail == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmpData(input string w, input logic [23:0] e,
                         input logic [23:0] g);
    checked++;
    if (g !== e) begin
      nFail++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic cmpCode(input string w, input logic [2:0] e,
                         input logic [2:0] g);
    checked++;
    if (g !== e) begin
      nFail++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic cmpBit(input string w, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      nFail++;
      $display("wrong value %s expected %b seen %b", w, e, g);
    end
  endtask
  task automatic frames(input int n);
    repeat (n * FRAME) @(negedge clk);
  endtask
  task automatic powerCycle();
    int k;
    powerUpReq = 1'h0;
    repeat (8) @(negedge clk);
    powerUpReq = 1'h1;
    for (k = 0; k < 3000 && analogMode !== sdsic_pkg::OUT_ACTIVE; k++)
      @(negedge clk);
    cmpCode("analogMode", 3'h2, {1'h0, analogMode});
  endtask
  task automatic sendPair(input logic [23:0] l, input logic [23:0] r);
    int k;
    leftIn = l;
    rightIn = r;
    for (k = 0; k < 3000 && (leftOut !== l || rightOut !== r); k++)
      @(negedge clk);
  endtask
  task automatic waitGain(input logic [10:0] v);
    int k;
    for (k = 0; k < (MUTE + 2) * FRAME && gainLevel !== v; k++)
      @(negedge clk);
  endtask

  initial begin
    int i;
    int k;
    {clk, clocksOn, powerUpReq, pinCtlReq, doubleReq} = 5'h08;
    {muteReq, timingResetReq, formatReq, deemphReq} = 7'h0D;
    {leftIn, rightIn} = 48'h000000000000;
    rst = 1'h1;
    repeat (6) @(negedge clk);
    rst = 1'h0;
    repeat (4) @(negedge clk);
    cmpCode("analogMode", 3'h0, {1'h0, analogMode});
    cmpBit("gainFull", 1'h1, gainLevel === 11'h400);
    cmpBit("zeroSeen", 1'h0, zeroSeen);
    cmpBit("externalMute", 1'h1, externalMute);
    for (i = 0; i < 7; i++) begin
      pinCtlReq = rows[i].pin;
      formatReq = rows[i].fmt;
      deemphReq = rows[i].dem;
      doubleReq = rows[i].dbl;
      powerCycle();
      sendPair(24'h800001 + 24'(i), 24'h123456 + 24'(i));
      if (rows[i].chk) begin
        cmpData("leftOut", 24'h800001 + 24'(i), leftOut);
        cmpData("rightOut", 24'h123456 + 24'(i), rightOut);
      end
      cmpCode("deemphSel", {1'h0, rows[i].expDem}, {1'h0, deemphSel});
      cmpBit("doubleRateOn", rows[i].dbl, doubleRateOn);
      cmpCode("ratio", rows[i].dbl ? 3'h3 : 3'h1, ratioSeen);
    end
    sendPair(24'h000000, 24'h000000);
    frames(ZERO - 6);
    cmpBit("zeroSeen", 1'h0, zeroSeen);
    for (k = 0; k < 12 * FRAME && zeroSeen !== 1'h1; k++)
      @(negedge clk);
    cmpBit("zeroSeen", 1'h1, zeroSeen);
    sendPair(24'h000100, 24'h000200);
    repeat (4) @(negedge clk);
    cmpBit("zeroSeen", 1'h0, zeroSeen);
    muteReq = 1'h1;
    frames(MUTE / 2);
    cmpBit("gainMid", 1'h1, gainLevel > 0 && gainLevel < 11'h400);
    muteReq = 1'h0;
    waitGain(11'h400);
    cmpBit("gainFull", 1'h1, gainLevel === 11'h400);
    muteReq = 1'h1;
    waitGain(11'h000);
    cmpBit("gainZero", 1'h1, gainLevel === 11'h000);
    frames(2);
    cmpData("leftOut", 24'h000000, leftOut);
    muteReq = 1'h0;
    frames(MUTE / 2);
    cmpBit("gainMid", 1'h1, gainLevel > 0 && gainLevel < 11'h400);
    sendPair(24'h000100, 24'h000200);
    cmpData("leftOut", 24'h000100, leftOut);
    timingResetReq = 1'h1;
    frames(2);
    cmpCode("analogMode", 3'h2, {1'h0, analogMode});
    {leftIn, rightIn} = 48'h000000000000;
    frames(4);
    cmpCode("analogMode", 3'h1, {1'h0, analogMode});
    cmpBit("zeroSeen", 1'h1, zeroSeen);
    cmpCode("deemphSel", 3'h1, {1'h0, deemphSel});
    cmpData("leftOut", 24'h000000, leftOut);
    timingResetReq = 1'h0;
    for (k = 0; k < 8 * FRAME && zeroSeen !== 1'h0; k++)
      @(negedge clk);
    cmpBit("zeroSeen", 1'h0, zeroSeen);
    for (k = 0; k < 4 * FRAME && analogMode !== sdsic_pkg::OUT_ACTIVE; k++)
      @(negedge clk);
    cmpCode("analogMode", 3'h2, {1'h0, analogMode});
    powerUpReq = 1'h0;
    repeat (6) @(negedge clk);
    cmpCode("analogMode", 3'h0, {1'h0, analogMode});
    cmpBit("zeroSeen", 1'h0, zeroSeen);
    cmpBit("externalMute", 1'h1, externalMute);
    clocksOn = 1'h0;
    frames(2);
    clocksOn = 1'h1;
    repeat (4) @(negedge clk);
    powerCycle();
    sendPair(24'h7FFFFF, 24'h000001);
    cmpData("leftOut", 24'h7FFFFF, leftOut);
    cmpData("rightOut", 24'h000001, rightOut);
    stopTest();
  end
endmodule
